// File: apqo_core.sv
`timescale 1ns/1ps

// Overview of operation
// - Freeze SPI angle and status at the frame's first serial clock edge.
// - Capture the angle at each PWM period start, hold it all period.
// - Refresh the low-power path angle register about every 32 us.
// - Refresh the field strength register 0x2A about every 128 us.
// - Power-up reloads shadow configuration from NVM; registers take defaults.
// - Power-up clears the extended write address pointer to zero.
// - PWM duty stays between 5% and 95%, 5% is zero degrees.
// - High first 5%, low last 5%, middle 90% proportional to angle.
// - 12-bit angle code; top code gives 4095/4096 of span plus lead.
// - Carrier frequency from 3-bit band and 4-bit step lookup, 128 choices.
// - A and B have 50% angular duty, 2^N cycles per revolution.
// - B leads A by a quarter cycle for increasing angle, four states per cycle.
// - One index pulse per revolution marks zero angle.
// - States one to four encode A,B as 00, 01, 11, 10.
// - Only A or B changes at once; forward up, backward down.
// - Exponent settings 3..14 map N 11..0; 0..2 reserved, 15 invalid.
// - Invert bit inverts A, B and index output levels.
// - Index rises at zero for increasing angle, falls for decreasing.
module apqo_core (
	input  wire logic                      ref_clk_i,
	input  wire logic                      resetn_i,
	input  wire logic [14:0]               angle_i,
	input  wire logic                      error_flag_i,
	input  wire logic                      undervoltage_i,
	input  wire logic [14:0]               zcd_angle_i,
	input  wire logic [15:0]               field_strength_i,
	input  wire apqo_pkg::apqo_shadow_type nvm_shadow_i,
	input  wire logic                      spi_csn_i,
	input  wire logic                      spi_sclk_i,
	input  wire logic                      write_ptr_we_i,
	input  wire logic [7:0]                write_ptr_i,
	output logic                           pwm_out_o,
	output logic                           pwm_oe_o,
	output logic                           enc_a_o,
	output logic                           enc_b_o,
	output logic                           enc_index_o,
	output apqo_pkg::apqo_snapshot_type    spi_snapshot_o,
	output logic [14:0]                    zcd_angle_reading_o,
	output logic [15:0]                    field_strength_reading_o,
	output logic [7:0]                     write_ptr_o,
	output apqo_pkg::apqo_shadow_type      shadow_o
);
	import apqo_pkg::*;

	logic                   shadow_loaded;
	logic [14:0]            angle_zeroed;
	logic [SEL_BITS-1:0]    sel;
	logic [PERIOD_BITS-1:0] period_tab [128];
	logic [PERIOD_BITS-1:0] lead_tab [128];
	logic [PERIOD_BITS-1:0] span_tab [128];
	logic [PERIOD_BITS-1:0] cnt;
	logic [PERIOD_BITS-1:0] period_q;
	logic [PERIOD_BITS-1:0] lead_q;
	logic [PERIOD_BITS-1:0] span_q;
	logic [PERIOD_BITS-1:0] high_q;
	logic [28:0]            span_prod;
	logic                   boundary;
	logic [1:0]             csn_sync;
	logic [2:0]             sclk_sync;
	logic                   first_seen;
	logic                   first_edge;
	logic [15:0]            zcd_cnt;
	logic [15:0]            field_cnt;
	logic [QUAD_BITS-1:0]   cur;
	logic [QUAD_BITS-1:0]   tgt;
	logic [QUAD_BITS-1:0]   diff;
	logic [QUAD_BITS-1:0]   qmask;
	logic [3:0]             qshift;
	logic [3:0]             qmsb;
	logic                   res_valid;
	logic                   next_a;
	logic                   next_b;

	// Masks a step count down to the active quadrature width.
	function automatic logic [QUAD_BITS-1:0] wrap(
		input logic [QUAD_BITS-1:0] v,
		input logic [QUAD_BITS-1:0] m);
		return v & m;
	endfunction

	// Period, lead and span per carrier choice, folded at elaboration.
	for (genvar g = 0; g < 128; g++) begin : g_tab
		assign period_tab[g] = PERIOD_BITS'(period_of(g));
		assign lead_tab[g]   =
			PERIOD_BITS'(period_of(g) * PWM_LEAD_PCT / PCT_FULL);
		assign span_tab[g]   =
			PERIOD_BITS'(period_of(g) * PWM_SPAN_PCT / PCT_FULL);
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			shadow_loaded <= 1'b0;
			shadow_o      <= '0;
		end else if (!shadow_loaded) begin
			shadow_loaded <= 1'b1;
			shadow_o      <= nvm_shadow_i;
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			write_ptr_o <= WRITE_PTR_RESET;
		end else if (write_ptr_we_i && shadow_loaded) begin
			write_ptr_o <= write_ptr_i;
		end
	end

	assign angle_zeroed = angle_i - shadow_o.zero_offset;

	assign sel = {shadow_o.carrier_band_select,
		shadow_o.carrier_step_select};
	assign boundary = (cnt == period_q - PERIOD_RESET);
	assign span_prod = span_tab[sel] *
		angle_zeroed[14 -: PWM_ANGLE_BITS];

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt      <= '0;
			period_q <= PERIOD_RESET;
			lead_q   <= '0;
			span_q   <= '0;
			high_q   <= '0;
		end else if (boundary) begin
			cnt      <= '0;
			period_q <= period_tab[sel];
			lead_q   <= lead_tab[sel];
			span_q   <= span_tab[sel];
			high_q   <= lead_tab[sel] +
				span_prod[PWM_ANGLE_BITS +: PERIOD_BITS];
		end else begin
			cnt <= cnt + PERIOD_RESET;
		end
	end

	// The pin is open drain: the enable pulls low, the pull-up makes high.
	// duty compare
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pwm_out_o <= 1'b0;
			pwm_oe_o  <= 1'b1;
		end else begin
			pwm_out_o <= 1'b0;
			pwm_oe_o  <= !shadow_loaded || (cnt >= high_q);
		end
	end

	// Serial pins are asynchronous to the core clock.
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			csn_sync  <= 2'h3;
			sclk_sync <= 3'h0;
		end else begin
			csn_sync  <= {csn_sync[0], spi_csn_i};
			sclk_sync <= {sclk_sync[1:0], spi_sclk_i};
		end
	end

	assign first_edge = !csn_sync[1] && !first_seen &&
		(sclk_sync[1] != sclk_sync[2]);

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			first_seen     <= 1'b0;
			spi_snapshot_o <= '0;
		end else if (csn_sync[1]) begin
			first_seen <= 1'b0;
		end else if (first_edge) begin
			first_seen     <= 1'b1;
			spi_snapshot_o <= '{error_flag_i, undervoltage_i,
				angle_zeroed[14 -: PWM_ANGLE_BITS], angle_zeroed};
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			zcd_cnt             <= '0;
			zcd_angle_reading_o <= '0;
		end else if (zcd_cnt == 16'(ZCD_CYCLES - 1)) begin
			zcd_cnt             <= '0;
			zcd_angle_reading_o <= zcd_angle_i;
		end else begin
			zcd_cnt <= zcd_cnt + 16'h0001;
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			field_cnt                <= '0;
			field_strength_reading_o <= '0;
		end else if (field_cnt == 16'(FIELD_CYCLES - 1)) begin
			field_cnt                <= '0;
			field_strength_reading_o <= field_strength_i;
		end else begin
			field_cnt <= field_cnt + 16'h0001;
		end
	end

	assign res_valid = (shadow_o.resolution >= RES_FIRST_VALID) &&
		(shadow_o.resolution <= RES_LAST_VALID);
	assign qshift = shadow_o.resolution - RES_SHIFT_BIAS;
	assign qmask  = {QUAD_BITS{1'b1}} >> (shadow_o.resolution -
		RES_FIRST_VALID);
	assign qmsb   = RES_WIDTH_BASE - shadow_o.resolution;
	assign tgt  = wrap(QUAD_BITS'(angle_zeroed >> qshift), qmask);
	assign diff = wrap(tgt - cur, qmask);

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cur <= '0;
		end else if (!shadow_loaded || !res_valid) begin
			cur <= '0;
		end else if (diff != '0) begin
			// direction
			// A target half a turn or more ahead is nearer going down.
			if (diff[qmsb] && diff != qmask >> 1)
				cur <= wrap(cur - QUAD_BITS'(1), qmask);
			else
				cur <= wrap(cur + QUAD_BITS'(1), qmask);
		end
	end

	always_comb begin
		case (apqo_quad_type'(cur[1:0]))
			QUAD_STATE_ONE: begin
				next_a = 1'b0;
				next_b = 1'b0;
			end
			QUAD_STATE_TWO: begin
				next_a = 1'b0;
				next_b = 1'b1;
			end
			QUAD_STATE_THREE: begin
				next_a = 1'b1;
				next_b = 1'b1;
			end
			default: begin
				next_a = 1'b1;
				next_b = 1'b0;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			enc_a_o     <= 1'b0;
			enc_b_o     <= 1'b0;
			enc_index_o <= 1'b0;
		end else begin
			enc_a_o     <= next_a ^ shadow_o.encoder_output_invert;
			enc_b_o     <= next_b ^ shadow_o.encoder_output_invert;
			enc_index_o <= (res_valid && shadow_loaded && cur == '0) ^
				shadow_o.encoder_output_invert;
		end
	end

	sequence first_sclk_s;
		!csn_sync[1] && first_edge;
	endsequence
	sequence frame_held_s;
		first_seen && !csn_sync[1];
	endsequence

	spi_latch_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		first_sclk_s |=> spi_snapshot_o.angle_long == $past(angle_zeroed))
		else $error("snapshot not taken at first edge");
	spi_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		frame_held_s ##1 !csn_sync[1] |-> $stable(spi_snapshot_o))
		else $error("snapshot changed during frame");
	pwm_angle_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		!$past(boundary) |-> $stable(high_q))
		else $error("pwm high time changed mid period");
	zcd_period_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		zcd_cnt == 16'(ZCD_CYCLES - 1) |=>
			zcd_angle_reading_o == $past(zcd_angle_i))
		else $error("zcd reading not refreshed");
	field_period_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		field_cnt == 16'(FIELD_CYCLES - 1) |=>
			field_strength_reading_o == $past(field_strength_i))
		else $error("field reading not refreshed");
	write_ptr_reset_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		!shadow_loaded |-> write_ptr_o == WRITE_PTR_RESET)
		else $error("write pointer not cleared");
	pwm_lead_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		shadow_loaded && !boundary && cnt < lead_q |=> !pwm_oe_o)
		else $error("pwm low in lead portion");
	pwm_tail_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		cnt >= lead_q + span_q |=> pwm_oe_o)
		else $error("pwm high in tail portion");
	quad_single_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		$stable(shadow_o) |=> !($changed(enc_a_o) && $changed(enc_b_o)))
		else $error("A and B changed together");
	index_zero_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		shadow_loaded && res_valid && cur == '0 && $stable(shadow_o) |=>
			enc_index_o != shadow_o.encoder_output_invert)
		else $error("index missing at zero");

endmodule

// File: apqo_pkg.sv
package apqo_pkg;

	localparam int unsigned CLK_HZ           = 10000000;
	localparam int unsigned ZCD_PERIOD_US    = 32;
	localparam int unsigned FIELD_PERIOD_US  = 128;
	localparam int unsigned ZCD_CYCLES       = CLK_HZ / 1000000 * ZCD_PERIOD_US;
	localparam int unsigned FIELD_CYCLES     =
		CLK_HZ / 1000000 * FIELD_PERIOD_US;
	localparam logic [7:0]  FIELD_STRENGTH_OFFSET = 8'h2a;
	localparam int unsigned PWM_LEAD_PCT     = 5;
	localparam int unsigned PWM_SPAN_PCT     = 90;
	localparam int unsigned PCT_FULL         = 100;
	localparam int unsigned PWM_ANGLE_BITS   = 12;
	localparam int unsigned PERIOD_BITS      = 17;
	localparam int unsigned QUAD_BITS        = 13;
	localparam int unsigned SEL_BITS         = 7;
	localparam logic [3:0]  RES_FIRST_VALID  = 4'h3;
	localparam logic [3:0]  RES_LAST_VALID   = 4'he;
	localparam logic [3:0]  RES_SHIFT_BIAS   = 4'h1;
	localparam logic [3:0]  RES_WIDTH_BASE   = 4'hf;
	localparam logic [7:0]  WRITE_PTR_RESET  = 8'h00;
	localparam logic [16:0] PERIOD_RESET     = 17'h00001;

	// Carrier frequencies in Hz, indexed by band * 16 + fine step.
	localparam int unsigned FREQ_TAB [128] = '{
		3125, 3101, 3077, 3053, 3030, 3008, 2985, 2963,
		2941, 2920, 2899, 2878, 2857, 2837, 2817, 2797,
		2778, 2740, 2703, 2667, 2632, 2597, 2564, 2532,
		2500, 2469, 2439, 2410, 2381, 2353, 2326, 2299,
		2273, 2222, 2174, 2128, 2083, 2041, 2000, 1961,
		1923, 1887, 1852, 1818, 1786, 1754, 1724, 1695,
		1667, 1613, 1563, 1515, 1471, 1429, 1389, 1351,
		1316, 1282, 1250, 1220, 1190, 1163, 1136, 1111,
		1087, 1042, 1000, 962, 926, 893, 862, 833,
		806, 781, 758, 735, 714, 694, 676, 658,
		641, 610, 581, 556, 532, 510, 490, 472,
		455, 439, 424, 410, 397, 385, 373, 362,
		352, 333, 316, 301, 287, 275, 263, 253,
		243, 234, 225, 217, 210, 203, 197, 191,
		185, 175, 166, 157, 150, 143, 137, 131,
		126, 121, 116, 112, 108, 105, 101, 98};

	typedef enum logic [1:0] {
		QUAD_STATE_ONE   = 2'b00,
		QUAD_STATE_TWO   = 2'b01,
		QUAD_STATE_THREE = 2'b10,
		QUAD_STATE_FOUR  = 2'b11
	} apqo_quad_type;

	typedef struct packed {
		logic [14:0] zero_offset;
		logic [3:0]  resolution;
		logic        encoder_output_invert;
		logic [2:0]  carrier_band_select;
		logic [3:0]  carrier_step_select;
	} apqo_shadow_type;

	typedef struct packed {
		logic        error_flag;
		logic        undervoltage;
		logic [11:0] angle_short;
		logic [14:0] angle_long;
	} apqo_snapshot_type;

	function automatic int unsigned period_of(input int unsigned idx);
		return CLK_HZ / FREQ_TAB[idx];
	endfunction

endpackage

// File: apqo_quad_rx.sv
`timescale 1ns/1ps

// Encoder receiver on the far side. Double steps are ignored on purpose,
// as a real receiver cannot tell their direction.
module apqo_quad_rx (
	input  wire logic        ref_clk_i,
	input  wire logic        resetn_i,
	input  wire logic        inv_i,
	input  wire logic        enc_a_i,
	input  wire logic        enc_b_i,
	input  wire logic [12:0] mask_i,
	output logic [12:0]      pos_o
);
	logic [1:0] last;
	logic [1:0] now;

	always_comb begin
		case ({enc_a_i ^ inv_i, enc_b_i ^ inv_i})
			2'b00:   now = 2'h0;
			2'b01:   now = 2'h1;
			2'b11:   now = 2'h2;
			default: now = 2'h3;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			last  <= 2'h0;
			pos_o <= 13'h0000;
		end else begin
			last <= now;
			if (now == last + 2'h1)
				pos_o <= (pos_o + 13'h0001) & mask_i;
			else if (now == last - 2'h1)
				pos_o <= (pos_o - 13'h0001) & mask_i;
		end
	end
endmodule

// File: tb_angle_pwm_quadrature_output.sv
`timescale 1ns/1ps

module tb_angle_pwm_quadrature_output;
	import apqo_pkg::*;
	logic              ref_clk_i = 1'b0;
	logic              resetn_i = 1'b0;
	logic [14:0]       angle_i = 15'h0000;
	logic              error_flag_i = 1'b0;
	logic              undervoltage_i = 1'b0;
	logic [14:0]       zcd_angle_i = 15'h0000;
	logic [15:0]       field_strength_i = 16'h0000;
	apqo_shadow_type   nvm_shadow_i = '0;
	logic              spi_csn_i = 1'b1;
	logic              spi_sclk_i = 1'b0;
	logic              write_ptr_we_i = 1'b0;
	logic [7:0]        write_ptr_i = 8'h00;
	logic              pwm_out_o, pwm_oe_o, enc_a_o, enc_b_o, enc_index_o;
	apqo_snapshot_type spi_snapshot_o;
	logic [14:0]       zcd_angle_reading_o;
	logic [15:0]       field_strength_reading_o;
	logic [7:0]        write_ptr_o;
	apqo_shadow_type   shadow_o;
	logic [12:0]       mask = 13'h0000;
	logic [12:0]       pos;
	logic              inv = 1'b0;
	logic [31:0]       seed = 32'h00000020;
	int                n_errors = 0;
	int                tests_run = 0;
	int                cycles = 0;

	apqo_core dut_u (
		.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .angle_i(angle_i),
		.error_flag_i(error_flag_i), .undervoltage_i(undervoltage_i),
		.zcd_angle_i(zcd_angle_i), .field_strength_i(field_strength_i),
		.nvm_shadow_i(nvm_shadow_i), .spi_csn_i(spi_csn_i),
		.spi_sclk_i(spi_sclk_i), .write_ptr_we_i(write_ptr_we_i),
		.write_ptr_i(write_ptr_i), .pwm_out_o(pwm_out_o),
		.pwm_oe_o(pwm_oe_o), .enc_a_o(enc_a_o), .enc_b_o(enc_b_o),
		.enc_index_o(enc_index_o), .spi_snapshot_o(spi_snapshot_o),
		.zcd_angle_reading_o(zcd_angle_reading_o),
		.field_strength_reading_o(field_strength_reading_o),
		.write_ptr_o(write_ptr_o), .shadow_o(shadow_o)
	);

	apqo_quad_rx rx_u (
		.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .inv_i(inv),
		.enc_a_i(enc_a_o), .enc_b_i(enc_b_o), .mask_i(mask), .pos_o(pos)
	);

	always #50 ref_clk_i = ~ref_clk_i;

	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 95000) begin
			n_errors++;
			complete_run();
		end
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic int trim(input int a);
		return (a - nvm_shadow_i.zero_offset) & 32'h7fff;
	endfunction

	task automatic check(input string what, input logic [31:0] exp,
			input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic near(input string what, input int exp, input int got);
		tests_run++;
		if (got > exp + 1 || got < exp - 1) begin
			n_errors++;
			$display("[ERR] %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	// The pin is high while the open-drain driver is off.
	task automatic pwm_meas(output int hi, output int per);
		hi = 0;
		while (pwm_oe_o !== 1'b1) @(negedge ref_clk_i);
		while (pwm_oe_o !== 1'b0) @(negedge ref_clk_i);
		while (pwm_oe_o === 1'b0) begin
			hi++;
			if (hi == 20)
				angle_i = 15'(rnd());
			@(negedge ref_clk_i);
		end
		per = hi;
		while (pwm_oe_o === 1'b1) begin
			per++;
			@(negedge ref_clk_i);
		end
	endtask

	task automatic session(input logic iv, input logic [3:0] res,
			input logic [6:0] sel, input int freq);
		int hi, per, pe, code, tgt;
		logic [31:0] r;
		logic [28:0] es;
		r = rnd();
		inv = iv;
		nvm_shadow_i = {r[14:0], res, iv, sel};
		mask = 13'((1 << (16 - res)) - 1);
		resetn_i = 1'b0;
		repeat (4) @(negedge ref_clk_i);
		resetn_i = 1'b1;
		repeat (2) @(negedge ref_clk_i);
		check("shadow", 32'(nvm_shadow_i), 32'(shadow_o));
		check("write_ptr", 32'h0, 32'(write_ptr_o));
		write_ptr_i = r[22:15];
		write_ptr_we_i = 1'b1;
		@(negedge ref_clk_i);
		write_ptr_we_i = 1'b0;
		@(negedge ref_clk_i);
		check("write_ptr", 32'(write_ptr_i), 32'(write_ptr_o));
		spi_csn_i = 1'b0;
		error_flag_i = r[23];
		undervoltage_i = r[24];
		angle_i = 15'(rnd());
		repeat (4) @(negedge ref_clk_i);
		spi_sclk_i = 1'b1;
		repeat (6) @(negedge ref_clk_i);
		code = trim(angle_i);
		es = {error_flag_i, undervoltage_i, 12'(code >> 3), 15'(code)};
		angle_i = ~angle_i;
		error_flag_i = ~error_flag_i;
		undervoltage_i = ~undervoltage_i;
		spi_sclk_i = 1'b0;
		repeat (6) @(negedge ref_clk_i);
		check("snapshot", 32'(es), 32'(spi_snapshot_o));
		spi_csn_i = 1'b1;
		zcd_angle_i = r[30:16];
		field_strength_i = r[15:0];
		repeat (330) @(negedge ref_clk_i);
		check("zcd", 32'(zcd_angle_i), 32'(zcd_angle_reading_o));
		repeat (970) @(negedge ref_clk_i);
		check("field", 32'(field_strength_i),
			32'(field_strength_reading_o));
		for (int i = 0; i < 10; i++) begin
			if (i == 0)
				angle_i = nvm_shadow_i.zero_offset;
			else
				angle_i = 15'(rnd());
			repeat (40) @(negedge ref_clk_i);
			tgt = trim(angle_i) >> (res - 1);
			check("quad_pos", 32'(tgt), 32'(pos));
			check("index", 32'((tgt == 0) ^ iv), 32'(enc_index_o));
		end
		pe = 10000000 / freq;
		for (int k = 0; k < 3; k++) begin
			code = (k == 0) ? 0 : (k == 1) ? 4095 : rnd() & 32'hfff;
			angle_i = 15'((code << 3) + nvm_shadow_i.zero_offset);
			pwm_meas(hi, per);
			check("pwm_period", 32'(pe), 32'(per));
			tgt = pe * 5 / 100 + ((pe * 90 / 100 * code) >> 12);
			near("pwm_high", tgt, hi);
		end
	endtask

	task automatic complete_run();
		if (n_errors == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		session(1'b0, 4'hc, 7'h00, 3125);
		session(1'b1, 4'hb, 7'h26, 2000);
		check("pwm_out", 32'h0, 32'(pwm_out_o));
		complete_run();
	end
endmodule
